// *** ie_pkg.sv ***
// Purpose: shared constants for the interrupt event block
// Assumes: 40 MHz register clock, APB register access
// Notes: offsets are byte addresses on the APB bus
package ie_pkg;
    // ==========================================
    // register map
    localparam logic [11:0] OFF_EVT_SET = 12'h080;
    localparam logic [11:0] OFF_EVT_CLR = 12'h084;
    localparam logic [11:0] OFF_MASK = 12'h088;
    localparam logic [11:0] OFF_LINK = 12'h08C;
    // ==========================================
    // event bit positions
    localparam int B_GP = 30;
    localparam int B_PHY_REG = 26;
    localparam int B_TOO_LONG = 25;
    localparam int B_FATAL = 24;
    localparam int B_MISMATCH = 23;
    localparam int B_MISSED = 22;
    localparam int B_SEC6 = 21;
    localparam int B_NEW_CYC = 20;
    localparam int B_PHY_STAT = 19;
    localparam int B_BUS_REINIT = 17;
    localparam int B_SELF_ID = 16;
    localparam int B_ISO_RX = 7;
    localparam int B_ISO_TX = 6;
    // link control bits
    localparam int L_ROOT_EN = 21;
    localparam int L_GP_EN_A = 0;
    localparam int L_GP_EN_B = 1;
    // ==========================================
    // field masks and reset values
    localparam logic [31:0] LATCH_BITS = 32'h47FB_033F;
    localparam logic [31:0] EXT_SRC_BITS = 32'h050B_033F;
    localparam logic [31:0] LINK_BITS = 32'h0020_0003;
    localparam logic [31:0] EVT_RESET = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;
    localparam logic [31:0] LINK_RESET = 32'h0000_0000;
    // ==========================================
    // timing
    localparam int CLK_PERIOD_PS = 25000;
    localparam int CYCLE_LIMIT_US = 125;
    localparam int CYCLE_LIMIT_CYC = (CYCLE_LIMIT_US * 1000000) / CLK_PERIOD_PS;
    // ==========================================
    // lost-cycle tracker states, gray along the path
    typedef enum logic [1:0] {
        CS_IDLE = 2'b00,
        CS_WAIT = 2'b01,
        CS_GAP = 2'b11,
        CS_DONE = 2'b10
    } ie_cs_state_t;
endpackage

// *** ie_cyc_if.sv ***
// Purpose: event pulses from the cycle monitor to the event core
// Assumes: single clock domain
// Notes: all event signals are one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
interface ie_cyc_if;
    logic root_en;
    logic too_long;
    logic mismatch;
    logic missed;
    logic sec_toggle;
    logic new_cycle;
    modport mon (input root_en, output too_long, mismatch, missed, sec_toggle, new_cycle);
    modport core (output root_en, input too_long, mismatch, missed, sec_toggle, new_cycle);
endinterface
`default_nettype wire

// *** ie_cycle_mon.sv ***
// Purpose: derive cycle timing events from the local cycle timer
// Assumes: link layer strobes are synchronous one-cycle pulses
// Notes: lost cycle may be reported early by prediction
`timescale 1ns/10ps
`default_nettype none
module ie_cycle_mon
    import ie_pkg::*;
#(
    parameter int CYC_LIMIT = CYCLE_LIMIT_CYC
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [31:0] i_cycle_timer,
    input wire logic i_cs_tx_start,
    input wire logic i_cs_seen,
    input wire logic i_rx_cs_valid,
    input wire logic [31:0] i_rx_cs_time,
    input wire logic i_sub_gap,
    input wire logic i_arb_gap,
    ie_cyc_if.mon cyc
);
    localparam int CW = $clog2(CYC_LIMIT + 2);
    localparam logic [CW-1:0] LIMIT = CW'(CYC_LIMIT);

    logic [1:0] tbit_ff;
    logic run_ff;
    logic [CW-1:0] cnt_ff;
    ie_cs_state_t st_ff, nxt_st;
    logic over;
    logic predict;

    // ==========================================
    // timer bit watch: seconds bit 6 and count lsb
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tbit_ff <= 2'h0;
        end else begin
            tbit_ff <= {i_cycle_timer[31], i_cycle_timer[12]};
        end
    end
    assign cyc.sec_toggle = tbit_ff[1] ^ i_cycle_timer[31];
    assign cyc.new_cycle = tbit_ff[0] ^ i_cycle_timer[12];
    // received cycle start against local seconds and count
    assign cyc.mismatch = i_rx_cs_valid &
        (i_rx_cs_time[31:12] != i_cycle_timer[31:12]);

    // ==========================================
    // overlong cycle: start of cycle start to end of subaction gap
    assign over = run_ff && (cnt_ff == LIMIT) && !i_sub_gap;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            run_ff <= 1'b0;
            cnt_ff <= '0;
        end else if (i_cs_tx_start && cyc.root_en) begin
            run_ff <= 1'b1;
            cnt_ff <= '0;
        end else if (i_sub_gap || over || !cyc.root_en) begin
            run_ff <= 1'b0;
        end else if (run_ff) begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end
    assign cyc.too_long = over && cyc.root_en;

    // ==========================================
    // lost cycle tracking per cycle synch
    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff)
            CS_IDLE: if (cyc.new_cycle) nxt_st = CS_WAIT;
            CS_WAIT: begin
                if (cyc.new_cycle) nxt_st = CS_WAIT;
                else if (i_cs_seen) nxt_st = CS_IDLE;
                else if (i_arb_gap) nxt_st = CS_DONE;
                else if (i_sub_gap) nxt_st = CS_GAP;
            end
            CS_GAP: begin
                if (cyc.new_cycle) nxt_st = CS_WAIT;
                else if (i_cs_seen) nxt_st = CS_IDLE;
                else nxt_st = CS_DONE;
            end
            CS_DONE: if (cyc.new_cycle) nxt_st = CS_WAIT;
        endcase
    end
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_ff <= CS_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end
    // early report when the cycle start fails to follow the gap
    assign predict = (nxt_st == CS_DONE) && (st_ff != CS_DONE);
    // plain loss: second synch with no cycle start in between
    assign cyc.missed = predict ||
        (cyc.new_cycle && (st_ff == CS_WAIT || st_ff == CS_GAP) && !i_cs_seen);
endmodule // ie_cycle_mon
`default_nettype wire

// *** ie_event_core.sv ***
// Purpose: interrupt event register with set and clear views
// Assumes: APB slave, zero wait states, 40 MHz clock
// Notes: reads return events gated by the interrupt mask
//
// Our own choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module ie_event_core
    import ie_pkg::*;
#(
    parameter int CYC_LIMIT = CYCLE_LIMIT_CYC,
    parameter int ISO_RX_N = 4,
    parameter int ISO_TX_N = 4
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // level event sources, bit aligned with the event register
    input wire logic [31:0] i_event_src,
    // event bits owned by contexts that raised the fatal halt
    input wire logic [31:0] i_fatal_ctx_bits,
    // general-purpose interrupt inputs
    input wire logic i_gp_irq_a,
    input wire logic i_gp_irq_b,
    // isochronous sub-events and their masks
    input wire logic [ISO_RX_N-1:0] i_iso_rx_event,
    input wire logic [ISO_RX_N-1:0] i_iso_rx_mask,
    input wire logic [ISO_TX_N-1:0] i_iso_tx_event,
    input wire logic [ISO_TX_N-1:0] i_iso_tx_mask,
    // cycle timing inputs from the link layer
    input wire logic [31:0] i_cycle_timer,
    input wire logic i_cs_tx_start,
    input wire logic i_cs_seen,
    input wire logic i_rx_cs_valid,
    input wire logic [31:0] i_rx_cs_time,
    input wire logic i_sub_gap,
    input wire logic i_arb_gap,
    // outputs
    output logic o_irq,
    output logic o_root_timing_enable
);

    // ==========================================
    // helpers
    function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
        return a == off;
    endfunction

    // ==========================================
    // state
    logic [31:0] evt_ff, nxt_evt;
    logic [31:0] mask_ff, nxt_mask;
    logic [31:0] link_ff, nxt_link;
    logic [31:0] src_ff;
    logic [1:0] gp_ff;
    logic [31:0] rdata_ff, nxt_rdata;
    logic err_ff, nxt_err;

    // ==========================================
    // cycle monitor
    ie_cyc_if cyc ();

    ie_cycle_mon #(
        .CYC_LIMIT(CYC_LIMIT)
    ) u_cycle_mon (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_cycle_timer(i_cycle_timer),
        .i_cs_tx_start(i_cs_tx_start),
        .i_cs_seen(i_cs_seen),
        .i_rx_cs_valid(i_rx_cs_valid),
        .i_rx_cs_time(i_rx_cs_time),
        .i_sub_gap(i_sub_gap),
        .i_arb_gap(i_arb_gap),
        .cyc(cyc)
    );

    assign cyc.root_en = link_ff[L_ROOT_EN];

    // ==========================================
    // apb decode
    wire logic acc = i_psel && i_penable;
    wire logic wr = acc && i_pwrite;
    wire logic hit_set = addr_is(i_paddr, OFF_EVT_SET);
    wire logic hit_clr = addr_is(i_paddr, OFF_EVT_CLR);
    wire logic hit_mask = addr_is(i_paddr, OFF_MASK);
    wire logic hit_link = addr_is(i_paddr, OFF_LINK);
    wire logic hit_any = hit_set || hit_clr || hit_mask || hit_link;
    wire logic [31:0] sw_set = (wr && hit_set) ? i_pwdata : 32'h0000_0000;
    wire logic [31:0] sw_clr = (wr && hit_clr) ? i_pwdata : 32'h0000_0000;

    // ==========================================
    // hardware set sources
    // only rising edges set bits, a held level never re-sets or clears
    wire logic [31:0] src_rise = i_event_src & ~src_ff & EXT_SRC_BITS;
    wire logic gp_fire = (i_gp_irq_a & ~gp_ff[0] & link_ff[L_GP_EN_A]) |
                         (i_gp_irq_b & ~gp_ff[1] & link_ff[L_GP_EN_B]);

    logic [31:0] cyc_set;
    always_comb begin
        cyc_set = 32'h0000_0000;
        cyc_set[B_TOO_LONG] = cyc.too_long;
        cyc_set[B_MISMATCH] = cyc.mismatch;
        cyc_set[B_MISSED] = cyc.missed;
        cyc_set[B_SEC6] = cyc.sec_toggle;
        cyc_set[B_NEW_CYC] = cyc.new_cycle;
        cyc_set[B_GP] = gp_fire;
    end

    // while halted, failed contexts may not raise further events
    wire logic [31:0] blocked = evt_ff[B_FATAL] ? i_fatal_ctx_bits : 32'h0000_0000;
    wire logic [31:0] hw_raw = src_rise | cyc_set;
    wire logic [31:0] hw_set = hw_raw & ~(blocked & ~(32'h1 << B_FATAL));

    // bus reset wipes self-id done in the same cycle it sets
    wire logic reinit = hw_set[B_BUS_REINIT];

    // ==========================================
    // event next value
    // set is applied after clear so a coincident event survives
    always_comb begin
        nxt_evt = (evt_ff & ~sw_clr) | hw_set | sw_set;
        if (reinit) begin
            nxt_evt[B_SELF_ID] = 1'b0;
        end
        nxt_evt = nxt_evt & LATCH_BITS;
    end

    // ==========================================
    // mask and link control
    // mask keeps the defined event bits plus the two summary enables
    assign nxt_mask = (wr && hit_mask) ? (i_pwdata & (LATCH_BITS | 32'h0000_00C0)) : mask_ff;

    // overlong cycle drops root timing after any software write
    always_comb begin
        nxt_link = link_ff;
        if (wr && hit_link) begin
            nxt_link = i_pwdata & LINK_BITS;
        end
        if (cyc.too_long) begin
            nxt_link[L_ROOT_EN] = 1'b0;
        end
    end

    // ==========================================
    // read view
    // summaries are never stored, so they follow sub-events at once
    wire logic iso_rx_sum = |(i_iso_rx_event & i_iso_rx_mask);
    wire logic iso_tx_sum = |(i_iso_tx_event & i_iso_tx_mask);

    logic [31:0] evt_view;
    always_comb begin
        evt_view = evt_ff & LATCH_BITS;
        evt_view[B_ISO_RX] = iso_rx_sum;
        evt_view[B_ISO_TX] = iso_tx_sum;
    end

    wire logic [31:0] masked_evt = evt_view & mask_ff & (LATCH_BITS | 32'h0000_00C0);

    always_comb begin
        nxt_rdata = rdata_ff;
        if (i_psel && !i_penable && !i_pwrite) begin
            if (hit_set || hit_clr) begin
                nxt_rdata = masked_evt;
            end else if (hit_mask) begin
                nxt_rdata = mask_ff;
            end else if (hit_link) begin
                nxt_rdata = link_ff;
            end else begin
                nxt_rdata = 32'h0000_0000;
            end
        end
    end

    // unmapped addresses answer with an error in the access phase
    assign nxt_err = (i_psel && !i_penable) ? !hit_any : err_ff;

    // ==========================================
    // registers
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            evt_ff <= EVT_RESET;
            mask_ff <= MASK_RESET;
            link_ff <= LINK_RESET;
        end else begin
            evt_ff <= nxt_evt;
            mask_ff <= nxt_mask;
            link_ff <= nxt_link;
        end
    end

    // edge history of sources
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            src_ff <= 32'h0000_0000;
            gp_ff <= 2'h0;
        end else begin
            src_ff <= i_event_src;
            gp_ff <= {i_gp_irq_b, i_gp_irq_a};
        end
    end

    // read data captured in setup, held through access
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rdata_ff <= 32'h0000_0000;
            err_ff <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            err_ff <= nxt_err;
        end
    end

    // ==========================================
    // outputs
    assign o_prdata = rdata_ff;
    assign o_pready = 1'b1; // no wait states
    assign o_pslverr = acc && err_ff;
    assign o_irq = |masked_evt;
    assign o_root_timing_enable = link_ff[L_ROOT_EN];

endmodule // ie_event_core
`default_nettype wire

// *** ie_event_core_asserts.sv ***
// Purpose: port level checks for the interrupt event block
// Assumes: apb writes land at the access edge, pready tied high
// Notes: mask and the gp A enable are rebuilt from observed bus writes
`timescale 1ns/10ps
`default_nettype none
module ie_event_core_asserts
    import ie_pkg::*;
#(
    parameter int ISO_RX_N = 4,
    parameter int ISO_TX_N = 4
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pslverr,
    input wire logic [31:0] i_event_src,
    input wire logic [31:0] i_fatal_ctx_bits,
    input wire logic i_gp_irq_a,
    input wire logic [ISO_RX_N-1:0] i_iso_rx_event,
    input wire logic [ISO_RX_N-1:0] i_iso_rx_mask,
    input wire logic [ISO_TX_N-1:0] i_iso_tx_event,
    input wire logic [ISO_TX_N-1:0] i_iso_tx_mask,
    input wire logic o_irq,
    input wire logic o_root_timing_enable
);
    // ==========================================
    // bus decode and shadows
    logic [31:0] mask_ff;
    logic gp_en_ff;
    wire acc = i_psel & i_penable;
    wire wr_mask = acc & i_pwrite & (i_paddr == OFF_MASK);
    wire wr_clr = acc & i_pwrite & (i_paddr == OFF_EVT_CLR);
    wire wr_link = acc & i_pwrite & (i_paddr == OFF_LINK);
    wire rd_evt = acc & !i_pwrite & (i_paddr == OFF_EVT_SET || i_paddr == OFF_EVT_CLR);
    wire iso_live = (|(i_iso_rx_event & i_iso_rx_mask)) | (|(i_iso_tx_event & i_iso_tx_mask));
    // anything that may legally pull the request line down
    wire drop_cause = wr_clr | wr_mask | iso_live | i_event_src[B_BUS_REINIT];
    wire [31:0] nxt_mask = wr_mask ? i_pwdata : mask_ff;
    wire nxt_gp_en = wr_link ? i_pwdata[L_GP_EN_A] : gp_en_ff;
    // shadows follow the same access edge as the device registers
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mask_ff <= 32'h0;
            gp_en_ff <= 1'h0;
        end else begin
            mask_ff <= nxt_mask;
            gp_en_ff <= nxt_gp_en;
        end
    end
    // ==========================================
    // properties
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    a_rsvd_read_zero: assert property (rd_evt |-> (o_prdata & 32'hB804_FC00) == 32'h0)
        else $error("reserved event bit read as one");
    a_read_masked: assert property (rd_evt |-> (o_prdata & ~mask_ff) == 32'h0)
        else $error("event read shows an unmasked bit");
    a_irq_needs_mask: assert property (mask_ff == 32'h0 |-> !o_irq)
        else $error("irq high with every mask bit off");
    a_phy_edge_irq: assert property ($rose(i_event_src[B_PHY_REG]) && mask_ff[B_PHY_REG]
        && !i_fatal_ctx_bits[B_PHY_REG] |=> o_irq) else $error("phy byte edge gave no irq");
    a_gp_edge_irq: assert property ($rose(i_gp_irq_a) && gp_en_ff && mask_ff[B_GP]
        && !i_fatal_ctx_bits[B_GP] |=> o_irq) else $error("gp input edge gave no irq");
    a_iso_summary: assert property ((|(i_iso_rx_event & i_iso_rx_mask)) && mask_ff[B_ISO_RX]
        |-> o_irq) else $error("iso receive summary missing from irq");
    a_iso_not_latched: assert property (rd_evt && !$past(iso_live)
        |-> o_prdata[B_ISO_RX:B_ISO_TX] == 2'h0) else $error("iso summary held after source");
    a_irq_holds: assert property ($fell(o_irq) |-> $past(drop_cause))
        else $error("irq dropped without a clear");
    // main scenarios reached
    c_clear_live: cover property (wr_clr && o_irq);
    c_root_drop: cover property ($fell(o_root_timing_enable));
    c_unmapped: cover property (acc && o_pslverr);
endmodule // ie_event_core_asserts
bind ie_event_core ie_event_core_asserts #(.ISO_RX_N(ISO_RX_N), .ISO_TX_N(ISO_TX_N)) i_chk (.*);
`default_nettype wire

// *** testbench.sv ***
// Purpose: directed register level bench for the interrupt event block
// Assumes: zero wait apb slave, short overlong limit for speed
// Notes: expectations are literals worked out by hand, except the shifted per-bit values of the hardware loop
`timescale 1ns/10ps
`default_nettype none
module testbench
    import ie_pkg::*;
;
    // ==========================================
    // stimulus and observed signals
    localparam int LIM = 20;
    logic i_clk = 1'h0;
    logic i_rstn = 1'h0;
    logic i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0;
    logic [11:0] i_paddr = 12'h0;
    logic [31:0] i_pwdata = 32'h0, i_event_src = 32'h0, i_fatal_ctx_bits = 32'h0;
    logic [31:0] i_cycle_timer = 32'h0, i_rx_cs_time = 32'h0;
    logic i_gp_irq_a = 1'h0, i_gp_irq_b = 1'h0, i_cs_tx_start = 1'h0, i_cs_seen = 1'h0;
    logic i_rx_cs_valid = 1'h0, i_sub_gap = 1'h0, i_arb_gap = 1'h0;
    logic [3:0] i_iso_rx_event = 4'h0, i_iso_rx_mask = 4'h0;
    logic [3:0] i_iso_tx_event = 4'h0, i_iso_tx_mask = 4'h0;
    logic [31:0] o_prdata, q, ev;
    logic o_pready, o_pslverr, o_irq, o_root_timing_enable, err;
    int miscompares = 0;
    int check_count = 0;
    int hw_bits[13] = '{26, 24, 19, 17, 16, 9, 8, 5, 4, 3, 2, 1, 0};
    ie_event_core #(.CYC_LIMIT(LIM)) i_dut (.*);
    always #12.5 i_clk = ~i_clk;
    // ==========================================
    // helpers
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // one transfer plus an idle cycle, so calls never collide in one time step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        i_psel <= 1'h1;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'h1;
        @(posedge i_clk);
        // only the watchdog ends a wait for ready
        while (o_pready !== 1'h1) begin
            @(posedge i_clk);
        end
        q = o_prdata;
        err = o_pslverr;
        i_psel <= 1'h0;
        i_penable <= 1'h0;
        @(posedge i_clk);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk($sformatf("read %h", a), q, exp);
    endtask
    task automatic rxcs(input logic [31:0] t);
        i_rx_cs_time <= t;
        i_rx_cs_valid <= 1'h1;
        tick(1);
        i_rx_cs_valid <= 1'h0;
        tick(1);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // watchdog, far beyond the roughly four hundred cycles the tests need
    initial begin
        #(25 * 20000);
        miscompares++;
        complete_run();
    end
    // ==========================================
    // tests
    initial begin
        tick(3);
        i_rstn <= 1'h1;
        tick(1);
        rdc(OFF_EVT_SET, 32'h0);
        rdc(OFF_MASK, 32'h0);
        rdc(OFF_LINK, 32'h0);
        apb(1'h0, 12'h090, 32'h0);
        chk("unmapped error", err, 32'h1);
        $display("test reset finished");
        apb(1'h1, OFF_MASK, 32'hFFFF_FFFF);
        apb(1'h1, OFF_EVT_SET, 32'hFFFF_FFFF);
        rdc(OFF_EVT_SET, 32'h47FB_033F);
        chk("irq", o_irq, 32'h1);
        apb(1'h1, OFF_EVT_CLR, 32'h0);
        rdc(OFF_EVT_CLR, 32'h47FB_033F);
        apb(1'h1, OFF_MASK, 32'h0400_0001);
        rdc(OFF_EVT_SET, 32'h0400_0001);
        apb(1'h1, OFF_MASK, 32'hFFFF_FFFF);
        apb(1'h1, OFF_EVT_CLR, 32'hFFFF_FFFF);
        rdc(OFF_EVT_SET, 32'h0);
        chk("irq", o_irq, 32'h0);
        $display("test software finished");
        // source falls before the read: the bit must stay
        foreach (hw_bits[k]) begin
            ev = 32'h1 << hw_bits[k];
            i_event_src <= ev;
            tick(2);
            i_event_src <= 32'h0;
            rdc(OFF_EVT_SET, ev);
            apb(1'h1, OFF_EVT_CLR, ev);
            rdc(OFF_EVT_SET, 32'h0);
        end
        apb(1'h1, OFF_EVT_SET, 32'h0001_0000);
        i_event_src <= 32'h0002_0000;
        tick(2);
        rdc(OFF_EVT_SET, 32'h0002_0000);
        i_fatal_ctx_bits <= 32'h0400_0000;
        i_event_src <= 32'h0100_0000;
        tick(2);
        i_event_src <= 32'h0500_0000;
        tick(2);
        rdc(OFF_EVT_SET, 32'h0102_0000);
        i_event_src <= 32'h0;
        apb(1'h1, OFF_EVT_CLR, 32'h0102_0000);
        i_event_src <= 32'h0400_0000;
        tick(2);
        rdc(OFF_EVT_SET, 32'h0400_0000);
        i_event_src <= 32'h0;
        i_fatal_ctx_bits <= 32'h0;
        apb(1'h1, OFF_EVT_SET, 32'h0008_0000);
        // source edge lands on the access edge of the clear
        fork
            apb(1'h1, OFF_EVT_CLR, 32'h0408_0000);
            begin
                @(posedge i_clk);
                i_event_src <= 32'h0008_0000;
            end
        join
        rdc(OFF_EVT_SET, 32'h0008_0000);
        i_event_src <= 32'h0;
        apb(1'h1, OFF_EVT_CLR, 32'hFFFF_FFFF);
        $display("test hardware finished");
        apb(1'h1, OFF_LINK, 32'h0000_0001);
        i_gp_irq_b <= 1'h1;
        tick(2);
        rdc(OFF_EVT_SET, 32'h0);
        i_gp_irq_a <= 1'h1;
        tick(2);
        rdc(OFF_EVT_SET, 32'h4000_0000);
        i_gp_irq_a <= 1'h0;
        i_gp_irq_b <= 1'h0;
        apb(1'h1, OFF_EVT_CLR, 32'hFFFF_FFFF);
        i_iso_rx_event <= 4'h2;
        i_iso_rx_mask <= 4'h2;
        i_iso_tx_event <= 4'h1;
        i_iso_tx_mask <= 4'h2;
        rdc(OFF_EVT_SET, 32'h0000_0080);
        i_iso_rx_event <= 4'h0;
        i_iso_tx_mask <= 4'h1;
        rdc(OFF_EVT_SET, 32'h0000_0040);
        i_iso_tx_event <= 4'h0;
        $display("test gp and iso finished");
        i_cycle_timer <= 32'h0000_1000;
        tick(2);
        rdc(OFF_EVT_SET, 32'h0010_0000);
        apb(1'h1, OFF_EVT_CLR, 32'hFFFF_FFFF);
        i_cycle_timer <= 32'h0;
        tick(2);
        rdc(OFF_EVT_SET, 32'h0050_0000);
        i_cs_seen <= 1'h1;
        apb(1'h1, OFF_EVT_CLR, 32'hFFFF_FFFF);
        i_cs_seen <= 1'h0;
        for (int k = 0; k < 2; k++) begin
            i_cycle_timer <= {~i_cycle_timer[31], 31'h0};
            tick(2);
            rdc(OFF_EVT_SET, 32'h0020_0000);
            apb(1'h1, OFF_EVT_CLR, 32'hFFFF_FFFF);
        end
        rxcs(32'h0000_0FFF);
        rdc(OFF_EVT_SET, 32'h0);
        rxcs(32'h0200_0000);
        rdc(OFF_EVT_SET, 32'h0080_0000);
        apb(1'h1, OFF_EVT_CLR, 32'hFFFF_FFFF);
        // predicted loss: gap with no cycle start, then arbitration reset gap
        for (int k = 0; k < 2; k++) begin
            i_cycle_timer <= {19'h0, ~i_cycle_timer[12], 12'h0};
            tick(1);
            i_sub_gap <= (k == 0);
            i_arb_gap <= (k == 1);
            tick(1);
            i_sub_gap <= 1'h0;
            i_arb_gap <= 1'h0;
            tick(2);
            rdc(OFF_EVT_SET, 32'h0050_0000);
            apb(1'h1, OFF_EVT_CLR, 32'hFFFF_FFFF);
        end
        $display("test cycle timer finished");
        apb(1'h1, OFF_LINK, 32'h0020_0000);
        i_cs_tx_start <= 1'h1;
        tick(1);
        i_cs_tx_start <= 1'h0;
        tick(5);
        i_sub_gap <= 1'h1;
        tick(1);
        i_sub_gap <= 1'h0;
        tick(LIM + 5);
        rdc(OFF_EVT_SET, 32'h0);
        i_cs_tx_start <= 1'h1;
        tick(1);
        i_cs_tx_start <= 1'h0;
        tick(LIM - 3);
        chk("root enable", o_root_timing_enable, 32'h1);
        tick(8);
        chk("root enable", o_root_timing_enable, 32'h0);
        rdc(OFF_EVT_SET, 32'h0200_0000);
        rdc(OFF_LINK, 32'h0);
        $display("test overlong finished");
        complete_run();
    end
endmodule // testbench
`default_nettype wire
